// ---- rtl/iopfm_consts.svh ----
// Constants of the I/O port function map: addresses, function codes, power-on map
`ifndef IOPFM_CONSTS_SVH
`define IOPFM_CONSTS_SVH

// Control-port addresses of the eight pin map registers
`define IOPFM_ADDR_PIN_FIRST 10'h00f
`define IOPFM_ADDR_PIN_LAST 10'h016

// Function code field layout
`define IOPFM_CODE_DIR_BIT 5
`define IOPFM_CODE_RESERVED 6'h00

// Output function codes
`define IOPFM_FN_FULL_FIELD_ERR 6'h01
`define IOPFM_FN_ACT_PIC_ERR 6'h02
`define IOPFM_FN_ANC_FLAG_ERR 6'h03
`define IOPFM_FN_CRC_ERR 6'h04
`define IOPFM_FN_SAV 6'h0d
`define IOPFM_FN_EAV 6'h0e
`define IOPFM_FN_SYNC_CHANGE 6'h0f
`define IOPFM_FN_F 6'h12
`define IOPFM_FN_V 6'h13
`define IOPFM_FN_H 6'h14
`define IOPFM_FN_FORMAT0 6'h15
`define IOPFM_FN_FIFO_FULL 6'h1a
`define IOPFM_FN_FIFO_EMPTY 6'h1b
`define IOPFM_FN_LOCK 6'h1c
`define IOPFM_FN_FIFO_OVERRUN 6'h1d
`define IOPFM_FN_CHKSUM_ERR 6'h1f

// Input function codes
`define IOPFM_FN_EDH_FORCE 6'h20
`define IOPFM_FN_PAT_SEL0 6'h21
`define IOPFM_FN_EDH_ENABLE 6'h27
`define IOPFM_FN_PG_ENABLE 6'h28
`define IOPFM_FN_IN_LAST 6'h28

// Power-on map, pin 0 in the low six bits
`define IOPFM_RESET_MAP 48'ha1d11c6544d2

// Self-test pattern words
`define IOPFM_BIST_525 6'h03
`define IOPFM_BIST_625 6'h11
`define IOPFM_PAT_COLOR_BARS 2'h3

`endif

// ---- rtl/iopfm_pkg.sv ----
// Types of the I/O port function map
package iopfm_pkg;

    typedef enum logic [0:0] {
        IOPFM_PH_ADDR = 1'b0,
        IOPFM_PH_DATA = 1'b1
    } iopfm_phase_t;

    typedef enum logic [1:0] {
        IOPFM_RATE_27 = 2'b00,
        IOPFM_RATE_36 = 2'b01,
        IOPFM_RATE_54 = 2'b10,
        IOPFM_RATE_NONE = 2'b11
    } iopfm_rate_t;

    typedef enum logic [1:0] {
        IOPFM_PAT_BLACK = 2'b00,
        IOPFM_PAT_PLL = 2'b01,
        IOPFM_PAT_EQ = 2'b10,
        IOPFM_PAT_BARS = 2'b11
    } iopfm_pattern_t;

endpackage : iopfm_pkg

// ---- rtl/iopfm_pattern_decode.sv ----
// Decoder of the test pattern select word and choice of self-test pattern
`timescale 1ns/1ps
`include "iopfm_consts.svh"

module iopfm_pattern_decode
    import iopfm_pkg::*;
(
    input wire logic [5:0] select_word, // Pattern select word
    input wire logic self_test, // Self-test requested
    output logic [5:0] active_word, // Word actually used
    output logic is_hd, // High-definition raster
    output logic sd_625, // 625-line standard definition
    output iopfm_rate_t sd_rate, // Standard-definition sample rate
    output iopfm_pattern_t pattern // Pattern kind
);

    // Self-test replaces the whole SD word, or only the pattern part of an HD word
    always_comb begin
        active_word = select_word;
        if (self_test) begin
            if (select_word[5]) begin
                active_word = {select_word[5:2], `IOPFM_PAT_COLOR_BARS}; // RULE_03
            end else if (select_word[4]) begin
                active_word = `IOPFM_BIST_625; // RULE_02
            end else begin
                active_word = `IOPFM_BIST_525; // RULE_02
            end
        end
    end

    // Field decode of the word in use
    always_comb begin
        is_hd = active_word[5]; // RULE_01
        sd_625 = !active_word[5] && active_word[4]; // RULE_01
        pattern = iopfm_pattern_t'(active_word[1:0]); // RULE_01
        if (active_word[5]) begin
            sd_rate = IOPFM_RATE_NONE;
        end else begin
            sd_rate = iopfm_rate_t'(active_word[3:2]); // RULE_01
        end
    end

endmodule : iopfm_pattern_decode

// ---- rtl/iopfm_top.sv ----
// Multi-function I/O port pin map with control-port programming and pattern decode
// What this block does
// RULE_01: SD pattern word fields: standard, rate, pattern
// RULE_02: SD self-test uses NTSC bars, PAL PLL
// RULE_03: HD self-test uses selected format's color bars
// RULE_04: Output codes select internal status indicators
// RULE_05: Input codes drive internal control bits
// RULE_06: Power-on pin map defaults, pin 7 input
// RULE_07: Code bit 5 sets pin direction
// RULE_08: Eight map registers at consecutive control addresses
// RULE_09: Controller writes address then data, one clock each
// RULE_10: Reserved codes drive nothing; outputs stay low
`timescale 1ns/1ps
`include "iopfm_consts.svh"

module iopfm_top
    import iopfm_pkg::*;
#(
    parameter int NUM_PINS = 8,
    parameter int CODE_W = 6
) (
    input wire logic clk_sys, // System clock, 10 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    // Control port pins
    input wire logic port_clk, // Control port clock pin
    input wire logic aux_or_control_select, // High for ancillary, low for control
    input wire logic rd_wr, // High read, low write
    input wire logic [9:0] port_data, // Control port data/address
    // Multi-function pins
    input wire logic [NUM_PINS-1:0] io_in, // Pin levels
    output logic [NUM_PINS-1:0] io_out, // Pin drive values
    output logic [NUM_PINS-1:0] io_oe, // High while a pin is driven
    // Internal status indicators
    input wire logic full_field_flag_error, // Full-field flag error
    input wire logic active_picture_flag_error, // Active-picture flag error
    input wire logic anc_flag_error, // Ancillary flag error
    input wire logic crc_error, // CRC error
    input wire logic sav_seen, // SAV
    input wire logic eav_seen, // EAV
    input wire logic sync_position_change_flag, // Sync position changed
    input wire logic field_bit, // F
    input wire logic vblank_bit, // V
    input wire logic hblank_bit, // H
    input wire logic [4:0] format_bits, // Format code
    input wire logic fifo_full, // FIFO full
    input wire logic fifo_empty, // FIFO empty
    input wire logic lock_detect, // Lock detect
    input wire logic fifo_overrun, // FIFO overrun
    input wire logic chksum_error, // Ancillary checksum error
    input wire logic self_test, // Self-test mode
    // Internal control bits
    output logic edh_force, // EDH force
    output logic [5:0] pattern_select, // Pattern select word from pins
    output logic edh_enable, // EDH enable
    output logic pattern_generator_enable, // Pattern generator enable
    output logic [5:0] pattern_word, // Word in use after self-test choice
    output logic pattern_is_hd, // HD raster selected
    output logic pattern_sd_625, // 625-line SD selected
    output iopfm_rate_t pattern_sd_rate, // SD rate
    output iopfm_pattern_t pattern_kind // Pattern kind
);

    localparam int NUM_IN_FN = 9;

    // Refuse parameter values that the fixed pin map cannot serve
    if (NUM_PINS != 8 || CODE_W != 6) begin : g_bad_params
        $error("iopfm_top serves eight pins with six-bit codes only");
    end

    // Output code is valid when it names a status indicator
    function automatic logic out_code_valid(input logic [5:0] code);
        out_code_valid = !code[`IOPFM_CODE_DIR_BIT] && (code != `IOPFM_CODE_RESERVED)
            && !(code > `IOPFM_FN_CRC_ERR && code < `IOPFM_FN_SAV)
            && (code != 6'h10) && (code != 6'h11) && (code != 6'h1e); // RULE_10
    endfunction : out_code_valid

    // Input code is valid when it names a control bit
    function automatic logic in_code_valid(input logic [5:0] code);
        in_code_valid = code[`IOPFM_CODE_DIR_BIT] && (code <= `IOPFM_FN_IN_LAST); // RULE_07
    endfunction : in_code_valid

    // Two-stage synchronisers for all pins
    logic [NUM_PINS+12:0] sync1_q, sync2_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {io_in, port_clk, aux_or_control_select, rd_wr, port_data};
            sync2_q <= sync1_q;
        end
    end

    logic [NUM_PINS-1:0] in_s;
    logic clk_s, sel_s, rw_s;
    logic [9:0] data_s;
    assign {in_s, clk_s, sel_s, rw_s, data_s} = sync2_q;

    // Control port write sequencer and map registers
    logic clk_prev_q, clk_prev_d;
    iopfm_phase_t phase_q, phase_d;
    logic [9:0] addr_q, addr_d;
    logic [CODE_W-1:0] map_q [NUM_PINS];
    logic [CODE_W-1:0] map_d [NUM_PINS];
    logic [9:0] pin_off;
    assign pin_off = addr_q - `IOPFM_ADDR_PIN_FIRST;

    always_comb begin
        clk_prev_d = clk_s;
        phase_d = phase_q;
        addr_d = addr_q;
        map_d = map_q;
        if (sel_s || rw_s) begin
            phase_d = IOPFM_PH_ADDR;
        end else if (clk_s && !clk_prev_q) begin
            if (phase_q == IOPFM_PH_ADDR) begin
                addr_d = data_s; // RULE_09
                phase_d = IOPFM_PH_DATA;
            end else begin
                phase_d = IOPFM_PH_ADDR;
                if (addr_q >= `IOPFM_ADDR_PIN_FIRST && addr_q <= `IOPFM_ADDR_PIN_LAST) begin
                    map_d[pin_off[2:0]] = data_s[CODE_W-1:0]; // RULE_08
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev_q <= 1'b0;
            phase_q <= IOPFM_PH_ADDR;
            addr_q <= '0;
            for (int i = 0; i < NUM_PINS; i++) begin
                map_q[i] <= CODE_W'(`IOPFM_RESET_MAP >> (i * 6)); // RULE_06
            end
        end else begin
            clk_prev_q <= clk_prev_d;
            phase_q <= phase_d;
            addr_q <= addr_d;
            map_q <= map_d;
        end
    end

    // Status indicators indexed by the low five code bits
    logic [31:0] st_vec;
    always_comb begin
        st_vec = '0;
        st_vec[1] = full_field_flag_error; // RULE_04
        st_vec[2] = active_picture_flag_error;
        st_vec[3] = anc_flag_error;
        st_vec[4] = crc_error;
        st_vec[13] = sav_seen;
        st_vec[14] = eav_seen;
        st_vec[15] = sync_position_change_flag;
        st_vec[18] = field_bit;
        st_vec[19] = vblank_bit;
        st_vec[20] = hblank_bit;
        st_vec[25:21] = format_bits;
        st_vec[26] = fifo_full;
        st_vec[27] = fifo_empty;
        st_vec[28] = lock_detect;
        st_vec[29] = fifo_overrun;
        st_vec[31] = chksum_error;
    end

    // Pin drive and direction per pin
    logic [NUM_PINS-1:0] out_d, out_q;
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
            assign io_oe[gp] = !map_q[gp][`IOPFM_CODE_DIR_BIT]; // RULE_07
            assign out_d[gp] = out_code_valid(map_q[gp]) ? st_vec[map_q[gp][4:0]] : 1'b0; // RULE_04 RULE_10
        end
    endgenerate

    // Control bits: OR of the input pins mapped to each function
    logic [NUM_IN_FN-1:0] ctrl_d, ctrl_q;
    genvar gf;
    generate
        for (gf = 0; gf < NUM_IN_FN; gf++) begin : g_fn
            always_comb begin
                ctrl_d[gf] = 1'b0;
                for (int p = 0; p < NUM_PINS; p++) begin
                    if (in_code_valid(map_q[p]) && map_q[p] == `IOPFM_FN_EDH_FORCE + 6'(gf)) begin
                        ctrl_d[gf] = ctrl_d[gf] | in_s[p]; // RULE_05
                    end
                end
            end
        end
    endgenerate

    // Pattern decode of the pin-driven select word
    logic [5:0] pw_d;
    logic hd_d, s625_d;
    iopfm_rate_t rate_d;
    iopfm_pattern_t kind_d;
    iopfm_pattern_decode u_decode (
        .select_word(ctrl_q[6:1]),
        .self_test(self_test),
        .active_word(pw_d),
        .is_hd(hd_d),
        .sd_625(s625_d),
        .sd_rate(rate_d),
        .pattern(kind_d)
    );

    // Output registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= '0;
            ctrl_q <= '0;
            pattern_word <= '0;
            pattern_is_hd <= 1'b0;
            pattern_sd_625 <= 1'b0;
            pattern_sd_rate <= IOPFM_RATE_27;
            pattern_kind <= IOPFM_PAT_BLACK;
        end else begin
            out_q <= out_d;
            ctrl_q <= ctrl_d;
            pattern_word <= pw_d;
            pattern_is_hd <= hd_d;
            pattern_sd_625 <= s625_d;
            pattern_sd_rate <= rate_d;
            pattern_kind <= kind_d;
        end
    end

    assign io_out = out_q;
    assign edh_force = ctrl_q[0];
    assign pattern_select = ctrl_q[6:1];
    assign edh_enable = ctrl_q[7];
    assign pattern_generator_enable = ctrl_q[8];

endmodule : iopfm_top

// ---- sim/iopfm_checker.sv ----
// Assertion checker of the I/O port function map
`timescale 1ns/1ps
module iopfm_checker
    import iopfm_pkg::*;
#(
    parameter int NUM_PINS = 8,
    parameter int CODE_W = 6
) (
    input wire logic clk_sys, // Clock
    input wire logic rst_n, // Reset
    input wire logic rd_wr, // Port direction
    input wire logic self_test, // Self-test
    input wire logic [NUM_PINS-1:0] io_oe, // Pin enables
    input wire logic [5:0] pattern_select, // Select word
    input wire logic [5:0] pattern_word, // Word in use
    input wire logic pattern_is_hd, // HD flag
    input wire logic pattern_sd_625, // 625 flag
    input wire iopfm_rate_t pattern_sd_rate, // SD rate
    input wire iopfm_pattern_t pattern_kind // Kind
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // Port held in read direction long enough to flush any write
    sequence s_read_idle;
        rd_wr [*8];
    endsequence
    property p_reset_map;
        $rose(rst_n) |-> io_oe == 8'h7f;
    endproperty
    property p_word;
        !$past(self_test) |-> pattern_word == $past(pattern_select);
    endproperty
    property p_bist_sd;
        $past(self_test) && !$past(pattern_select[5]) |-> pattern_word == ($past(pattern_select[4]) ? 6'h11 : 6'h03);
    endproperty
    property p_bist_hd;
        $past(self_test) && $past(pattern_select[5]) |-> pattern_word == {$past(pattern_select[5:2]), 2'b11};
    endproperty
    property p_hd_flag;
        pattern_is_hd == pattern_word[5];
    endproperty
    property p_kind;
        pattern_kind == pattern_word[1:0];
    endproperty
    property p_sd_fields;
        !pattern_word[5] |-> pattern_sd_625 == pattern_word[4] && (&pattern_word[3:2] || pattern_sd_rate == pattern_word[3:2]);
    endproperty
    property p_read_quiet;
        s_read_idle |=> $stable(io_oe);
    endproperty
    a_reset_map: assert property (p_reset_map) else $error("pin map not at defaults");
    a_word: assert property (p_word) else $error("word does not follow select");
    a_bist_sd: assert property (p_bist_sd) else $error("wrong SD self-test word");
    a_bist_hd: assert property (p_bist_hd) else $error("wrong HD self-test word");
    a_hd_flag: assert property (p_hd_flag) else $error("HD flag wrong");
    a_kind: assert property (p_kind) else $error("pattern kind wrong");
    a_sd_fields: assert property (p_sd_fields) else $error("SD fields wrong");
    a_read_quiet: assert property (p_read_quiet) else $error("map changed without write");
endmodule : iopfm_checker

// ---- sim/iopfm_host_model.sv ----
// Controller model that programs the pin map over the control port
`timescale 1ns/1ps
module iopfm_host_model (
    input wire logic clk_sys, // System clock
    output logic port_clk, // Control port clock
    output logic aux_or_control_select, // Low for control access
    output logic rd_wr, // Low for write
    output logic [9:0] port_data // Address, then data
);
    // Idle: deselected, read direction, clock low
    initial begin
        port_clk = 1'b0;
        aux_or_control_select = 1'b1;
        rd_wr = 1'b1;
        port_data = 10'h3ff;
    end
    // One port clock pulse, value set up first, each level held four clocks
    task automatic pulse(input logic [9:0] v);
        port_data = v;
        @(negedge clk_sys);
        port_clk = 1'b1;
        repeat (4) @(negedge clk_sys);
        port_clk = 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask : pulse
    // Address phase then data phase; rd high turns it into a read
    task automatic write_map(input logic [9:0] addr, input logic [5:0] code, input logic rd);
        @(negedge clk_sys);
        aux_or_control_select = 1'b0;
        rd_wr = rd;
        repeat (4) @(negedge clk_sys);
        pulse(addr);
        pulse({4'h0, code});
        aux_or_control_select = 1'b1;
        rd_wr = 1'b1;
        port_data = ~port_data; // Released bus shows no stale value
        repeat (4) @(negedge clk_sys);
    endtask : write_map
endmodule : iopfm_host_model

// ---- sim/iopfm_top_tb.sv ----
// Self-checking bench of the I/O port function map
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s exp %h got %h", n, e, g); end end
module iopfm_top_tb;
    import iopfm_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic self_test = 1'b0;
    logic [7:0] io_in = 8'h80;
    logic [19:0] st = 20'h64280;
    logic port_clk, aux_or_control_select, rd_wr;
    logic [9:0] port_data;
    logic [7:0] io_out, io_oe;
    logic edh_force, edh_enable, pattern_generator_enable, pattern_is_hd, pattern_sd_625;
    logic [5:0] pattern_select, pattern_word, w, e;
    iopfm_rate_t pattern_sd_rate;
    iopfm_pattern_t pattern_kind;
    logic [5:0] ocode [20] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h0d, 6'h0e, 6'h0f, 6'h12, 6'h13, 6'h14,
        6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d, 6'h1f};
    logic [5:0] rcode [6] = '{6'h00, 6'h05, 6'h0c, 6'h10, 6'h11, 6'h1e};
    int n_fail = 0;
    int n_checks = 0;
    // Clock
    always #50 clk_sys = ~clk_sys;
    iopfm_host_model iopfm_host_model_i (.clk_sys, .port_clk, .aux_or_control_select, .rd_wr, .port_data);
    iopfm_top iopfm_top_i (.clk_sys, .rst_n, .port_clk, .aux_or_control_select, .rd_wr, .port_data, .io_in,
        .io_out, .io_oe, .full_field_flag_error(st[0]), .active_picture_flag_error(st[1]), .anc_flag_error(st[2]),
        .crc_error(st[3]), .sav_seen(st[4]), .eav_seen(st[5]), .sync_position_change_flag(st[6]),
        .field_bit(st[7]), .vblank_bit(st[8]), .hblank_bit(st[9]), .format_bits(st[14:10]), .fifo_full(st[15]),
        .fifo_empty(st[16]), .lock_detect(st[17]), .fifo_overrun(st[18]), .chksum_error(st[19]), .self_test,
        .edh_force, .pattern_select, .edh_enable, .pattern_generator_enable, .pattern_word, .pattern_is_hd,
        .pattern_sd_625, .pattern_sd_rate, .pattern_kind);
    // Verdict and end of run
    task automatic report_and_stop;
        if (n_fail == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    // Map write followed by settling time
    task automatic wr(input logic [9:0] a, input logic [5:0] c);
        iopfm_host_model_i.write_map(a, c, 1'b0);
        repeat (2) @(negedge clk_sys);
    endtask : wr
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        report_and_stop();
    end
    // Test sequence
    initial begin
        repeat (12) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        `CHK("oe", 8'h7f, io_oe)
        `CHK("out", 7'h5d, io_out[6:0])
        `CHK("pg_en", 1'b1, pattern_generator_enable)
        wr(10'h00e, 6'h20);
        wr(10'h017, 6'h20);
        iopfm_host_model_i.write_map(10'h00f, 6'h20, 1'b1);
        `CHK("oe", 8'h7f, io_oe)
        for (int k = 0; k < 8; k++) begin
            wr(10'h00f + 10'(k), 6'h20);
            `CHK("oe", 8'h7f & (8'hfe << k), io_oe)
        end
        io_in = 8'h02;
        for (int j = 0; j < 10; j++) begin
            wr(10'h010, 6'h20 + 6'(j));
            `CHK("ctl", 9'(10'h1 << j), {pattern_generator_enable, edh_enable, pattern_select, edh_force})
            `CHK("dir", 1'b0, io_oe[1])
        end
        for (int i = 0; i < 26; i++) begin
            w = i < 20 ? ocode[i] : rcode[i - 20];
            wr(10'h00f, w);
            st = i < 20 ? 20'h1 << i : 20'hfffff;
            repeat (2) @(negedge clk_sys);
            `CHK("pin", i < 20, io_out[0])
            `CHK("dir", 1'b1, io_oe[0])
            `CHK("pin7", 1'b0, io_out[7])
            st = ~st;
            repeat (2) @(negedge clk_sys);
            `CHK("pin", 1'b0, io_out[0])
        end
        for (int k = 0; k < 6; k++) begin
            wr(10'h00f + 10'(k), 6'h21 + 6'(k));
        end
        for (int i = 0; i < 64; i++) begin
            w = 6'(i);
            io_in = {2'b00, w};
            self_test = 1'b0;
            repeat (5) @(negedge clk_sys);
            `CHK("sel", w, pattern_select)
            `CHK("word", w, pattern_word)
            `CHK("kind", w[1:0], pattern_kind)
            `CHK("hd", w[5], pattern_is_hd)
            if (!w[5] && w[3:2] != 2'b11) begin
                `CHK("rate", w[3:2], pattern_sd_rate)
                `CHK("625", w[4], pattern_sd_625)
            end else begin
                `CHK("rate", 2'h3, pattern_sd_rate)
                `CHK("625", !w[5] && w[4], pattern_sd_625)
            end
            self_test = 1'b1;
            e = w[5] ? {w[5:2], 2'b11} : (w[4] ? 6'h11 : 6'h03);
            repeat (2) @(negedge clk_sys);
            `CHK("bist", e, pattern_word)
        end
        self_test = 1'b0;
        rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        `CHK("oe", 8'h7f, io_oe)
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        report_and_stop();
    end
endmodule : iopfm_top_tb

bind iopfm_top iopfm_checker #(.NUM_PINS(NUM_PINS), .CODE_W(CODE_W)) iopfm_checker_i (.clk_sys, .rst_n, .rd_wr,
    .self_test, .io_oe, .pattern_select, .pattern_word, .pattern_is_hd, .pattern_sd_625, .pattern_sd_rate, .pattern_kind);
